// ==== rtl/phc_top.sv ====
// Purpose: output handshake engine with timing, inhibit and polarity
// Assumes: sense lines are asynchronous; register port is synchronous
// Notes:   holds the output FIFO module and the top module

`timescale 1ns/1ns
`default_nettype none

module phc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             ce_i,
    // fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output var  logic             in_ready_o,
    // drain side
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;

    // handshake terms
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign cnt_d       = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    // storage
    always_ff @(posedge clk_i)
    begin
        if (ce_i && push)
        begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // pointers, fill count and registered ready
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_q       <= '0;
            rd_q       <= '0;
            cnt_q      <= '0;
            in_ready_o <= 1'b0;
        end
        else if (ce_i)
        begin
            wr_q       <= wr_q + AW'(push);
            rd_q       <= rd_q + AW'(pop);
            cnt_q      <= cnt_d;
            in_ready_o <= (cnt_d != (AW+1)'(DEPTH));
        end
    end
endmodule

module phc_top
    import phc_pkg::*;
#(
    parameter int COARSE_CYC = COARSE_STEP_CYC
) (
    // clock, reset, enable
    input  wire logic          clk_i,
    input  wire logic          reset_n_i,
    input  wire logic          ce_i,
    // register port
    input  wire logic [3:0]    reg_addr_i,
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    input  wire logic [7:0]    reg_wdata_i,
    output var  logic [7:0]    reg_rdata_o,
    // output data stream
    input  wire logic          out_valid_i,
    input  wire phc_word_type  out_word_i,
    output logic               out_ready_o,
    // peripheral lines
    input  wire phc_sense_type sense_i,
    output var  phc_req_type   req_o,
    output var  logic [3:0][7:0] port_data_o
);
    // -------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------
    logic [7:0]      line_pol_q;
    logic [7:0]      data_hs_q;
    logic [7:0]      delay_q;
    logic [7:0]      inhibit_q;
    logic [3:0]      sense_s1_q;
    logic [3:0]      sense_s2_q;
    logic [3:0]      busy;
    phc_state_type   state_q;
    phc_method_type  method;
    phc_word_type    head;
    logic            head_valid;
    logic            pop;
    logic            sel_b;
    logic            cur_b_q;
    logic            flag_busy;
    logic            inh_true;
    logic            req_logic_q;
    logic            tmr_start;
    logic            tmr_run_q;
    logic            tmr_done_q;
    logic [10:0]     min_cnt_q;
    logic [14:0]     step_cnt_q;
    logic [14:0]     step_len_q;
    logic [6:0]      incr_q;
    logic [3:0][7:0] port_logic_q;

    // -------------------------------------------------------------
    // output FIFO
    // -------------------------------------------------------------
    phc_fifo #(
        .WIDTH ($bits(phc_word_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .ce_i        (ce_i),
        .in_valid_i  (out_valid_i),
        .in_data_i   (out_word_i),
        .in_ready_o  (out_ready_o),
        .out_valid_o (head_valid),
        .out_data_o  (head),
        .out_ready_i (pop)
    );

    // -------------------------------------------------------------
    // line sensing
    // -------------------------------------------------------------
    // two-flop synchroniser on flag and status lines
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sense_s1_q <= '0;
            sense_s2_q <= '0;
        end
        else if (ce_i)
        begin
            sense_s1_q <= sense_i;
            sense_s2_q <= sense_s1_q;
        end
    end

    // normalised busy: high is busy unless inverted
    assign busy      = sense_s2_q ^ line_pol_q[7:4];
    assign method    = phc_method_type'(data_hs_q[7:6]);
    assign sel_b     = (state_q == ST_IDLE) ? head.port[0] : cur_b_q;
    assign flag_busy = sel_b ? busy[1] : busy[0];
    // status zero guards request A, status one request B
    assign inh_true  = inhibit_q[INH_EN_BIT]
                       & (sel_b ? busy[3] : busy[2]);
    // start only when not inhibited (and flag ready for full)
    assign pop = (state_q == ST_IDLE) && head_valid && !inh_true
                 && !(method == HS_FULL && flag_busy);
    assign tmr_start = (pop && method != HS_NONE)
                       || (state_q == ST_LEAD && tmr_done_q
                           && method == HS_STROBE);

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    // handshake line polarity
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            line_pol_q <= REG_RESET;
        else if (ce_i && reg_wr_i && reg_addr_i == REG_LINE_POL)
            line_pol_q <= reg_wdata_i;
    end

    // data polarity and method, one write for both groups
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            data_hs_q <= REG_RESET;
        else if (ce_i && reg_wr_i && reg_addr_i == REG_DATA_HS)
            data_hs_q <= reg_wdata_i & DATA_HS_MASK;
    end

    // delay count and range
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            delay_q <= REG_RESET;
        else if (ce_i && reg_wr_i && reg_addr_i == REG_DELAY)
            delay_q <= reg_wdata_i;
    end

    // inhibit enable, bit 0 only
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            inhibit_q <= REG_RESET;
        else if (ce_i && reg_wr_i && reg_addr_i == REG_INHIBIT)
            inhibit_q <= reg_wdata_i & INHIBIT_MASK;
    end

    // read back
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            reg_rdata_o <= REG_RESET;
        else if (ce_i && reg_rd_i)
        begin
            if (reg_addr_i == REG_LINE_POL)
                reg_rdata_o <= line_pol_q;
            else if (reg_addr_i == REG_DATA_HS)
                reg_rdata_o <= data_hs_q;
            else if (reg_addr_i == REG_DELAY)
                reg_rdata_o <= delay_q;
            else if (reg_addr_i == REG_INHIBIT)
                reg_rdata_o <= inhibit_q;
            else if (reg_addr_i == REG_STATUS)
            begin
                reg_rdata_o            <= REG_RESET;
                reg_rdata_o[STAT_BUSY] <= (state_q != ST_IDLE);
                reg_rdata_o[STAT_INH]  <= head_valid && inh_true;
                reg_rdata_o[STAT_FULL] <= !out_ready_o;
            end
            else
                reg_rdata_o <= REG_RESET;
        end
    end

    // -------------------------------------------------------------
    // delay timer: minimum gap, then count increments
    // -------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            tmr_run_q  <= 1'b0;
            tmr_done_q <= 1'b0;
            min_cnt_q  <= '0;
            step_cnt_q <= '0;
            step_len_q <= '0;
            incr_q     <= '0;
        end
        else if (ce_i)
        begin
            tmr_done_q <= 1'b0;
            if (tmr_start)
            begin
                tmr_run_q  <= 1'b1;
                min_cnt_q  <= 11'(MIN_GAP_CYC - 1);
                incr_q     <= delay_q[6:0];
                step_len_q <= delay_q[RANGE_BIT]
                              ? 15'(COARSE_CYC - 1)
                              : 15'(FINE_STEP_CYC - 1);
                step_cnt_q <= delay_q[RANGE_BIT]
                              ? 15'(COARSE_CYC - 1)
                              : 15'(FINE_STEP_CYC - 1);
            end
            else if (tmr_run_q)
            begin
                if (min_cnt_q != '0)
                    min_cnt_q <= min_cnt_q - 11'h001;
                else if (incr_q != '0)
                begin
                    if (step_cnt_q != '0)
                        step_cnt_q <= step_cnt_q - 15'h0001;
                    else
                    begin
                        step_cnt_q <= step_len_q;
                        incr_q     <= incr_q - 7'h01;
                    end
                end
                else
                begin
                    tmr_run_q  <= 1'b0;
                    tmr_done_q <= 1'b1;
                end
            end
        end
    end

    // -------------------------------------------------------------
    // output handshake sequencer
    // -------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q     <= ST_IDLE;
            req_logic_q <= 1'b0;
            cur_b_q     <= 1'b0;
        end
        else if (ce_i)
        begin
            case (state_q)
                ST_IDLE:
                    if (pop)
                    begin
                        cur_b_q <= head.port[0];
                        if (method != HS_NONE)
                            state_q <= ST_LEAD;
                    end
                ST_LEAD:
                    if (tmr_done_q)
                    begin
                        req_logic_q <= 1'b1;
                        state_q     <= ST_REQ;
                    end
                ST_REQ:
                    if (method == HS_STROBE)
                    begin
                        if (tmr_done_q)
                        begin
                            req_logic_q <= 1'b0;
                            state_q     <= ST_IDLE;
                        end
                    end
                    else if (flag_busy)
                    begin
                        req_logic_q <= 1'b0;
                        state_q <= (method == HS_FULL) ? ST_FLAG
                                                       : ST_IDLE;
                    end
                ST_FLAG:
                    if (!flag_busy)
                        state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // request pins: logical level through polarity, aux idle false
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            req_o <= '0;
        else if (ce_i)
            req_o <= {1'b0, req_logic_q & cur_b_q, 1'b0,
                      req_logic_q & ~cur_b_q} ^ line_pol_q[3:0];
    end

    // -------------------------------------------------------------
    // data ports with per-port inversion
    // -------------------------------------------------------------
    for (genvar i = 0; i < 4; i++)
    begin : g_port
        always_ff @(posedge clk_i or negedge reset_n_i)
        begin
            if (!reset_n_i)
            begin
                port_logic_q[i] <= '0;
                port_data_o[i]  <= '0;
            end
            else if (ce_i)
            begin
                if (pop && head.port == 2'(i))
                    port_logic_q[i] <= head.data;
                port_data_o[i] <= port_logic_q[i]
                                  ^ {8{data_hs_q[i]}};
            end
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    logic [23:0] lead_cnt_q;
    logic [23:0] lead_exp_q;

    // lead-time measurement against the programmed value
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            lead_cnt_q <= '0;
            lead_exp_q <= '0;
        end
        else if (ce_i)
        begin
            lead_cnt_q <= tmr_start ? 24'h000000 : lead_cnt_q + 24'h1;
            if (tmr_start)
                lead_exp_q <= 24'(MIN_GAP_CYC) + 24'(delay_q[6:0])
                    * (delay_q[RANGE_BIT] ? 24'(COARSE_CYC)
                                          : 24'(FINE_STEP_CYC));
        end
    end

    sequence s_lead_end;
        state_q == ST_LEAD && tmr_done_q;
    endsequence

    property p_lead_time;
        @(posedge clk_i) disable iff (!reset_n_i || !ce_i)
        s_lead_end |-> lead_cnt_q >= lead_exp_q
                       && lead_cnt_q <= lead_exp_q + 24'h3;
    endproperty
    a_lead_time: assert property (p_lead_time)
        else $error("request delay out of range");

    property p_strobe_width;
        @(posedge clk_i) disable iff (!reset_n_i || !ce_i)
        state_q == ST_REQ && method == HS_STROBE && tmr_done_q
        |-> lead_cnt_q >= lead_exp_q;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("strobe pulse too short");

    property p_inhibit_hold;
        @(posedge clk_i) disable iff (!reset_n_i || !ce_i)
        state_q == ST_IDLE && head_valid && inh_true
        |=> state_q == ST_IDLE && !req_logic_q;
    endproperty
    a_inhibit_hold: assert property (p_inhibit_hold)
        else $error("output started while inhibited");

    property p_no_inhibit;
        @(posedge clk_i) disable iff (!reset_n_i || !ce_i)
        state_q == ST_IDLE && head_valid && !inhibit_q[INH_EN_BIT]
        && method == HS_STROBE |=> state_q == ST_LEAD;
    endproperty
    a_no_inhibit: assert property (p_no_inhibit)
        else $error("strobe output did not start");

    property p_inhibit_line;
        @(posedge clk_i) disable iff (!reset_n_i || !ce_i)
        state_q == ST_IDLE && head_valid && inhibit_q[INH_EN_BIT]
        && !head.port[0] && busy[2] |=> state_q == ST_IDLE;
    endproperty
    a_inhibit_line: assert property (p_inhibit_line)
        else $error("status zero ignored for port A request");

    property p_req_pol;
        @(posedge clk_i) disable iff (!reset_n_i || !ce_i)
        ##2 req_o.port_a_request_line
            == (($past(req_logic_q) && !$past(cur_b_q))
                ^ $past(line_pol_q[0]));
    endproperty
    a_req_pol: assert property (p_req_pol)
        else $error("request A level wrong");

    property p_none_quiet;
        @(posedge clk_i) disable iff (!reset_n_i || !ce_i)
        state_q == ST_IDLE && method == HS_NONE
        |=> state_q == ST_IDLE && !req_logic_q;
    endproperty
    a_none_quiet: assert property (p_none_quiet)
        else $error("request raised with no handshake");

    property p_full_release;
        @(posedge clk_i) disable iff (!reset_n_i || !ce_i)
        state_q == ST_REQ && method == HS_FULL && flag_busy
        |=> state_q == ST_FLAG && !req_logic_q;
    endproperty
    a_full_release: assert property (p_full_release)
        else $error("full handshake did not release request");

    property p_readback;
        @(posedge clk_i) disable iff (!reset_n_i || !ce_i)
        reg_wr_i && reg_addr_i == REG_INHIBIT
        ##1 reg_rd_i && reg_addr_i == REG_INHIBIT && !reg_wr_i
        |=> reg_rdata_o == ($past(reg_wdata_i, 2) & INHIBIT_MASK);
    endproperty
    a_readback: assert property (p_readback)
        else $error("inhibit register read back wrong");
endmodule

`default_nettype wire

// ==== rtl/phc_pkg.sv ====
// Purpose: constants and types for the parallel handshake configuration
// Assumes: 20 MHz clock, register port addressed by register number
// Notes:   coarse step count is a top-level parameter
//
// Operation
// - timing register sets request delay and strobe pulse width
// - programmed delay adds to a fixed minimum of about 60 us
// - timing bits 0..6 count increments, bit 7 picks increment size
// - range bit clear: each increment is 10 us
// - range bit set: coarse increment, taken as 1 ms
// - inhibit register uses bit 0 only; set enables output inhibit
// - inhibit disabled: output handshakes run unchanged
// - port-A request uses status zero, port-B request status one
// - inhibit not for ports already handshaking on status lines
// - sample inhibit before each output cycle, wait while true
// - inhibit works with every handshake method
// - polarity bit 0 gives positive-true, 1 negative-true
// - polarity bits: reqA, aux0, reqB, aux1, flagA, flagB, st0, st1
// - flag/status high is busy at 0; request high is true at 0
// - negative-true reads low as one, positive-true the reverse
// - request polarity change moves the driven level at once
// - data register bits 0..3 invert ports A..D; bit 4 unused
// - one write sets handshake and data polarity bits together
// - handshake value 128 selects strobe handshake
// - bits 7:6 select method: full, partial, strobe, none
// - bit 5 selects input timing: ready-to-busy or busy-to-ready; here bit 5 is stored and read back but never used

package phc_pkg;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_KHZ         = 20000;
    localparam int MIN_GAP_US      = 60;
    localparam int FINE_STEP_US    = 10;
    localparam int COARSE_STEP_MS  = 1;
    localparam int MIN_GAP_CYC     = MIN_GAP_US * CLK_KHZ / 1000;
    localparam int FINE_STEP_CYC   = FINE_STEP_US * CLK_KHZ / 1000;
    localparam int COARSE_STEP_CYC = COARSE_STEP_MS * CLK_KHZ;

    // -------------------------------------------------------------
    // register numbers and fields
    // -------------------------------------------------------------
    localparam logic [3:0] REG_LINE_POL = 4'h3;
    localparam logic [3:0] REG_DATA_HS  = 4'h4;
    localparam logic [3:0] REG_DELAY    = 4'h6;
    localparam logic [3:0] REG_INHIBIT  = 4'h9;
    localparam logic [3:0] REG_STATUS   = 4'ha;
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [7:0] DATA_HS_MASK = 8'hef;
    localparam logic [7:0] INHIBIT_MASK = 8'h01;
    localparam int         RANGE_BIT    = 7;
    localparam int         INH_EN_BIT   = 0;
    localparam int         STAT_BUSY    = 0;
    localparam int         STAT_INH     = 1;
    localparam int         STAT_FULL    = 2;
    localparam int         FIFO_DEPTH   = 32;

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        HS_FULL    = 2'b00,
        HS_PARTIAL = 2'b01,
        HS_STROBE  = 2'b10,
        HS_NONE    = 2'b11
    } phc_method_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LEAD = 2'b01,
        ST_REQ  = 2'b10,
        ST_FLAG = 2'b11
    } phc_state_type;

    typedef struct packed {
        logic aux_request_one;
        logic port_b_request_line;
        logic aux_request_zero;
        logic port_a_request_line;
    } phc_req_type;

    typedef struct packed {
        logic status_line_one;
        logic status_line_zero;
        logic port_b_flag_line;
        logic port_a_flag_line;
    } phc_sense_type;

    typedef struct packed {
        logic [1:0] port;
        logic [7:0] data;
    } phc_word_type;

endpackage

// ==== verification/phc_periph_model.sv ====
// Purpose: peripheral model on the flag and status lines
// Assumes: pol_i mirrors the line polarity register of the block
// Notes:   flag goes busy a few cycles after a true request
`timescale 1ns/1ns
`default_nettype none
module phc_periph_model
    import phc_pkg::*;
(
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          reset_n_i,
    // lines and settings
    input  wire phc_req_type   req_i,
    input  wire logic [7:0]    pol_i,
    input  wire logic [1:0]    inhibit_i,
    output var  phc_sense_type sense_o
);
    logic [2:0] flag_a_q;
    logic [2:0] flag_b_q;
    // busy follows the logical request late
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            flag_a_q <= 3'h0;
            flag_b_q <= 3'h0;
        end
        else
        begin
            flag_a_q <= {flag_a_q[1:0], req_i[0] ^ pol_i[0]};
            flag_b_q <= {flag_b_q[1:0], req_i[2] ^ pol_i[2]};
        end
    end
    // line levels from busy state and polarity
    assign sense_o.port_a_flag_line = flag_a_q[2] ^ pol_i[4];
    assign sense_o.port_b_flag_line = flag_b_q[2] ^ pol_i[5];
    assign sense_o.status_line_zero = inhibit_i[0] ^ pol_i[6];
    assign sense_o.status_line_one  = inhibit_i[1] ^ pol_i[7];
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench for the handshake configuration block
// Assumes: coarse step shortened to 50 cycles
// Notes:   inhibit also holds the FIFO for the fill test
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import phc_pkg::*;
;
    localparam int CC = 50;
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    logic            ce = 1'b1;
    logic            wr = 1'b0;
    logic            rd = 1'b0;
    logic            vld = 1'b0;
    logic [3:0]      addr = 4'h0;
    logic [7:0]      wdat = 8'h00;
    logic [7:0]      pol = 8'h00;
    logic [1:0]      inh = 2'h0;
    phc_word_type    word = '0;
    logic [7:0]      rdat;
    logic            rdy;
    phc_sense_type   sense;
    phc_req_type     req;
    logic [3:0][7:0] pdat;
    int              err_total = 0;
    int              n_compared = 0;
    int              cyc = 0;
    // clock
    always #25 clk = ~clk;
    phc_top #(.COARSE_CYC(CC)) dut_u (.clk_i(clk), .reset_n_i(rst_n),
        .ce_i(ce), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_wdata_i(wdat), .reg_rdata_o(rdat), .out_valid_i(vld),
        .out_word_i(word), .out_ready_o(rdy), .sense_i(sense),
        .req_o(req), .port_data_o(pdat));
    phc_periph_model model_u (.clk_i(clk), .reset_n_i(rst_n), .req_i(req),
        .pol_i(pol), .inhibit_i(inh), .sense_o(sense));
    task automatic chk(input logic [7:0] s, input logic [7:0] e,
                       input string m);
        n_compared++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %0t %s: got %h want %h", $time, m, s, e);
        end
    endtask
    task automatic rng(input int c, input int lo, input string m);
        chk(8'(c >= lo && c <= lo + 8), 8'h01, m);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        #5 addr = a;
        wdat = d;
        wr = 1'b1;
        @(posedge clk);
        #5 wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        addr = a;
        rd = 1'b1;
        @(posedge clk);
        #5 rd = 1'b0;
        @(posedge clk);
        #5 d = rdat;
    endtask
    task automatic push(input logic [1:0] p, input logic [7:0] d);
        @(posedge clk);
        #5 word = {p, d};
        vld = 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        #5 vld = 1'b0;
    endtask
    // cycles until request bit b reaches level lv
    task automatic wait_req(input int b, input logic lv, input int mx,
                            output int c);
        c = 0;
        while (req[b] !== lv && c < mx)
        begin
            @(posedge clk);
            #1 c++;
        end
    endtask
    task automatic t_regs;
        logic [3:0] a [5] = '{4'h3, 4'h4, 4'h6, 4'h9, 4'h5};
        logic [7:0] e [5] = '{8'hff, 8'hef, 8'hff, 8'h01, 8'h00};
        logic [7:0] v;
        for (int i = 0; i < 5; i++)
        begin
            rd_reg(a[i], v);
            chk(v, REG_RESET, "reset value");
            wr_reg(a[i], 8'hff);
            rd_reg(a[i], v);
            chk(v, e[i], "readback");
            wr_reg(a[i], 8'h00);
        end
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(4'h3, 8'(1 << i));
            repeat (2) @(posedge clk);
            #1 chk({4'h0, req}, 8'(1 << i), "request polarity");
        end
        wr_reg(4'h3, 8'h00);
        ce = 1'b0;
        wr_reg(4'h3, 8'h0f);
        ce = 1'b1;
        rd_reg(4'h3, v);
        chk(v, 8'h00, "write taken while disabled");
        $display("test regs done");
    endtask
    task automatic t_strobe(input logic [7:0] d6, input int lo);
        int c;
        wr_reg(4'h4, 8'h81);
        wr_reg(4'h6, d6);
        push(2'd0, 8'h5a);
        wait_req(0, 1'b1, 9000, c);
        rng(c, lo, "request delay");
        chk(pdat[0], 8'ha5, "port A inverted");
        wait_req(0, 1'b0, 9000, c);
        rng(c, lo, "strobe width");
        $display("test strobe done");
    endtask
    task automatic t_full(input logic [7:0] m);
        int c;
        pol = 8'h20;
        wr_reg(4'h3, 8'h20);
        wr_reg(4'h4, m);
        wr_reg(4'h6, 8'h00);
        push(2'd1, m ^ 8'h3c);
        wait_req(2, 1'b1, 1400, c);
        rng(c, MIN_GAP_CYC, "full lead");
        chk(pdat[1], m ^ 8'h3c, "port B data");
        wait_req(2, 1'b0, 40, c);
        chk(8'(c < 40), 8'h01, "request drops on busy flag");
        pol = 8'h00;
        wr_reg(4'h3, 8'h00);
        $display("test full done");
    endtask
    task automatic t_inhibit;
        int n;
        logic [7:0] v;
        wr_reg(4'h4, 8'hc0);
        wr_reg(4'h9, 8'h01);
        inh = 2'b01;
        repeat (4) @(posedge clk);
        n = 0;
        #5 word = {2'd2, 8'h00};
        vld = 1'b1;
        repeat (40)
        begin
            @(posedge clk);
            if (rdy === 1'b1) n++;
            #5 word = {2'd2, 8'(n)};
        end
        vld = 1'b0;
        chk(8'(n), 8'd32, "fifo depth");
        chk(pdat[2], 8'h00, "held by inhibit");
        rd_reg(4'ha, v);
        chk(v, 8'h06, "status while held");
        inh = 2'b00;
        n = 0;
        while (pdat[2] !== 8'd31 && n < 45000)
        begin
            @(posedge clk);
            n++;
        end
        chk(pdat[2], 8'd31, "drained");
        chk({4'h0, req}, 8'h00, "no request in none");
        inh = 2'b10;
        push(2'd2, 8'h77);
        repeat (1500) @(posedge clk);
        chk(pdat[2], 8'h77, "status one ignored on C");
        inh = 2'b00;
        $display("test inhibit done");
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // run limit
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 95000)
        begin
            err_total++;
            $display("[FAIL] %0t run limit reached", $time);
            tally_and_finish();
        end
    end
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        #5 rst_n = 1'b1;
        t_regs();
        t_strobe(8'd20, MIN_GAP_CYC + 20 * FINE_STEP_CYC);
        t_strobe(8'h82, MIN_GAP_CYC + 2 * CC);
        t_full(8'h00);
        t_full(8'h40);
        t_inhibit();
        tally_and_finish();
    end
endmodule
`default_nettype wire
